// file: logic/sopma_cell.sv
// one macrocell: sum terms, polarity, optional flip-flop, pin enable, feedback
`timescale 1ns/100ps
`default_nettype none

module sopma_cell (
  // clock and reset
  input  wire logic                             clk_sys,
  input  wire logic                             rst,
  // array side
  input  wire logic [sopma_pkg::LITS-1:0]       lits,
  input  wire logic [sopma_pkg::TERMS*sopma_pkg::LITS-1:0] masks,
  input  wire logic [sopma_pkg::LITS-1:0]       keep,
  // configuration
  input  wire logic                             registered,
  input  wire logic                             invert,
  input  wire sopma_pkg::sopma_oe_e             oe_mode,
  input  wire sopma_pkg::sopma_dir_e            dir,
  input  wire logic                             global_oe,
  // pin side
  input  wire logic                             pin_in,
  output var  logic                             pin_out,
  output var  logic                             pin_oe,
  // array feedback and state
  output var  logic                             feedback,
  output wire logic                             q
);
  import sopma_pkg::*;

  logic [TERMS-1:0] hits;
  logic             sum_val;
  logic             pol_val;
  logic             q_reg;
  logic             q_next;
  logic             oe_raw;

  // every term, the enable term included, sees the whole literal vector
  genvar t;
  generate
    for (t = 0; t < TERMS; t++) begin : g_term
      sopma_term u_term (
        .lits (lits),
        .mask (masks[t*LITS +: LITS]),
        .keep (keep),
        .hit  (hits[t])
      );
    end
  endgenerate

  // fixed OR of the sum terms, then polarity
  assign sum_val = |hits[SUM_TERMS-1:0];
  assign pol_val = sum_val ^ invert;

  // flip-flop always follows; the output and feedback muxes decide if it is used
  always_comb begin
    q_next = pol_val;
  end

  // power-up clear is modelled by the reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q_reg <= CELL_Q_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

  // enable source; the dedicated term keeps its own slot
  always_comb begin
    case (oe_mode)
      SOPMA_OE_TERM:   oe_raw = hits[OE_TERM];
      SOPMA_OE_ALWAYS: oe_raw = 1'b1;
      SOPMA_OE_GLOBAL: oe_raw = global_oe;
      default:         oe_raw = 1'b0;
    endcase
  end

  // pin drive, direction override and feedback source
  always_comb begin
    pin_out = registered ? q_reg : pol_val;
    case (dir)
      SOPMA_DIR_IN:  pin_oe = 1'b0;
      SOPMA_DIR_OUT: pin_oe = 1'b1;
      default:       pin_oe = oe_raw;
    endcase
    // registered cells bypass the pin; an input-only pin is read back instead
    if (registered && (dir != SOPMA_DIR_IN)) begin
      feedback = q_reg;
    end else begin
      feedback = pin_in;
    end
  end

endmodule : sopma_cell
`default_nettype wire

// file: logic/sopma_pkg.sv
// constants, layouts and modes shared by the sum-of-products macrocell array
package sopma_pkg;

  // array geometry
  localparam int CELLS      = 8;
  localparam int SUM_TERMS  = 8;
  localparam int TERMS      = SUM_TERMS + 1;
  localparam int OE_TERM    = SUM_TERMS;
  localparam int DED_LARGE  = 14;
  localparam int DED_SMALL  = 10;
  localparam int SIGS       = DED_LARGE + CELLS;
  localparam int LITS       = 2 * SIGS;
  localparam int LITS_SMALL = 2 * (DED_SMALL + CELLS);
  localparam int SLOTS      = CELLS * TERMS;
  localparam int GSEL_W     = 4;

  // literals of dedicated inputs 10..13 vanish on the smaller variant
  localparam logic [LITS-1:0] LIT_KEEP_LARGE = 44'hFFFFFFFFFFF;
  localparam logic [LITS-1:0] LIT_KEEP_SMALL = 44'hFFFF00FFFFF;

  // register bus geometry, word addressed
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;
  localparam int TERM_HI_W = LITS - DATA_W;

  // register word indices
  localparam logic [ADDR_W-1:0] REG_GLOBAL_CTRL = 9'h000;
  localparam logic [ADDR_W-1:0] REG_STATUS      = 9'h001;
  localparam logic [ADDR_W-1:0] REG_INPUTS      = 9'h002;
  localparam logic [ADDR_W-1:0] REG_CELL_BASE   = 9'h010;
  localparam logic [ADDR_W-1:0] REG_TERM_BASE   = 9'h100;
  localparam logic [7:0]        TERM_WORDS      = 8'h90;

  // global control fields
  localparam int CTRL_SMALL_BIT = 0;
  localparam int CTRL_GSEL_LSB  = 8;

  // per-cell configuration fields
  localparam int CELL_CFG_W   = 6;
  localparam int CELL_REG_BIT = 0;
  localparam int CELL_INV_BIT = 1;
  localparam int CELL_OE_LSB  = 2;
  localparam int CELL_DIR_LSB = 4;

  // values after reset
  localparam logic                  CTRL_SMALL_RST = 1'b0;
  localparam logic [GSEL_W-1:0]     CTRL_GSEL_RST  = 4'h0;
  localparam logic [CELL_CFG_W-1:0] CELL_CFG_RST   = 6'h00;
  localparam logic [DATA_W-1:0]     TERM_LO_RST    = 32'h00000000;
  localparam logic [TERM_HI_W-1:0]  TERM_HI_RST    = 12'h000;
  localparam logic                  CELL_Q_RST     = 1'b0;

  // output enable source of a cell
  typedef enum logic [1:0] {
    SOPMA_OE_TERM,
    SOPMA_OE_ALWAYS,
    SOPMA_OE_GLOBAL,
    SOPMA_OE_NEVER
  } sopma_oe_e;

  // pin use of a cell
  typedef enum logic [1:0] {
    SOPMA_DIR_BIDIR,
    SOPMA_DIR_IN,
    SOPMA_DIR_OUT,
    SOPMA_DIR_SPARE
  } sopma_dir_e;

endpackage : sopma_pkg

// file: logic/sopma_term.sv
// one programmable AND product term over the literal vector
`timescale 1ns/100ps
`default_nettype none

module sopma_term (
  // literals and programming
  input  wire logic [sopma_pkg::LITS-1:0] lits,
  input  wire logic [sopma_pkg::LITS-1:0] mask,
  input  wire logic [sopma_pkg::LITS-1:0] keep,
  // result
  output wire logic                       hit
);
  import sopma_pkg::*;

  logic [LITS-1:0] eff_mask;

  // a term with no literal is unused and reads false, like an erased cell
  assign eff_mask = mask & keep;
  assign hit      = (|eff_mask) & (&(~eff_mask | lits));

endmodule : sopma_term
`default_nettype wire

// file: logic/sopma_top.sv
// top of the sum-of-products macrocell array with its Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none

module sopma_top (
  // clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              rst,
  // Avalon-MM slave
  input  wire logic [sopma_pkg::ADDR_W-1:0]      avs_address,
  input  wire logic                              avs_read,
  input  wire logic                              avs_write,
  input  wire logic [sopma_pkg::DATA_W-1:0]      avs_writedata,
  input  wire logic [sopma_pkg::BE_W-1:0]        avs_byteenable,
  output var  logic [sopma_pkg::DATA_W-1:0]      avs_readdata,
  output var  logic                              avs_waitrequest,
  // dedicated inputs
  input  wire logic [sopma_pkg::DED_LARGE-1:0]   ded_in,
  // macrocell pins
  input  wire logic [sopma_pkg::CELLS-1:0]       pin_in,
  output wire logic [sopma_pkg::CELLS-1:0]       pin_out,
  output wire logic [sopma_pkg::CELLS-1:0]       pin_oe
);
  import sopma_pkg::*;

  // ---- configuration state
  logic                                 small_reg;
  logic                                 small_next;
  logic [GSEL_W-1:0]                    gsel_reg;
  logic [GSEL_W-1:0]                    gsel_next;
  logic [CELL_CFG_W-1:0]                cell_cfg_reg  [CELLS];
  logic [CELL_CFG_W-1:0]                cell_cfg_next [CELLS];
  logic [DATA_W-1:0]                    term_lo_reg   [SLOTS];
  logic [DATA_W-1:0]                    term_lo_next  [SLOTS];
  logic [TERM_HI_W-1:0]                 term_hi_reg   [SLOTS];
  logic [TERM_HI_W-1:0]                 term_hi_next  [SLOTS];

  // ---- bus state
  logic                                 wait_reg;
  logic                                 wait_next;
  logic [DATA_W-1:0]                    rdata_reg;
  logic [DATA_W-1:0]                    rdata_next;

  // ---- decode
  logic                                 wr_commit;
  logic                                 hit_ctrl;
  logic                                 hit_status;
  logic                                 hit_inputs;
  logic                                 hit_cell;
  logic                                 hit_term;
  logic [2:0]                           cell_idx;
  logic [6:0]                           term_idx;
  logic                                 term_hi_sel;
  logic [DATA_W-1:0]                    hi_merged;
  logic [DATA_W-1:0]                    lo_merged;
  logic [DATA_W-1:0]                    rd_word;

  // ---- array nets
  logic [SIGS-1:0]                      sigs;
  logic [LITS-1:0]                      lits;
  logic [LITS-1:0]                      keep;
  logic [CELLS-1:0][TERMS*LITS-1:0]     cell_masks;
  logic [CELLS-1:0]                     feedback;
  logic [CELLS-1:0]                     cell_q;
  logic                                 global_oe;

  // ---- per-cell fields
  logic [CELLS-1:0]                     cell_registered;
  logic [CELLS-1:0]                     cell_invert;
  sopma_oe_e                            cell_oe_mode  [CELLS];
  sopma_dir_e                           cell_dir      [CELLS];

  // merge written bytes into a stored word
  function automatic logic [DATA_W-1:0] be_merge(
    input logic [DATA_W-1:0] old_v,
    input logic [DATA_W-1:0] new_v,
    input logic [BE_W-1:0]   be
  );
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // a write lands only on the edge that also shows waitrequest low
  assign wr_commit   = avs_write && !wait_reg;

  // address decode, word indices
  assign hit_ctrl    = (avs_address == REG_GLOBAL_CTRL);
  assign hit_status  = (avs_address == REG_STATUS);
  assign hit_inputs  = (avs_address == REG_INPUTS);
  assign hit_cell    = (avs_address[ADDR_W-1:3] == REG_CELL_BASE[ADDR_W-1:3]);
  assign hit_term    = avs_address[ADDR_W-1] && (avs_address[7:0] < TERM_WORDS);
  assign cell_idx    = avs_address[2:0];
  assign term_idx    = avs_address[7:1];
  assign term_hi_sel = avs_address[0];

  // byte-merged words for the addressed term; only 12 bits of the high word exist
  assign hi_merged   = be_merge({20'h00000, term_hi_reg[term_idx]}, avs_writedata,
                                avs_byteenable);
  assign lo_merged   = be_merge(term_lo_reg[term_idx], avs_writedata, avs_byteenable);

  // configuration next values; unmapped writes fall through untouched
  always_comb begin
    small_next = small_reg;
    gsel_next  = gsel_reg;
    for (int c = 0; c < CELLS; c++) begin
      cell_cfg_next[c] = cell_cfg_reg[c];
    end
    for (int s = 0; s < SLOTS; s++) begin
      term_lo_next[s] = term_lo_reg[s];
      term_hi_next[s] = term_hi_reg[s];
    end
    if (wr_commit) begin
      if (hit_ctrl) begin
        if (avs_byteenable[0]) begin
          small_next = avs_writedata[CTRL_SMALL_BIT];
        end
        if (avs_byteenable[1]) begin
          gsel_next = avs_writedata[CTRL_GSEL_LSB +: GSEL_W];
        end
      end else if (hit_cell) begin
        if (avs_byteenable[0]) begin
          cell_cfg_next[cell_idx] = avs_writedata[CELL_CFG_W-1:0];
        end
      end else if (hit_term) begin
        if (term_hi_sel) begin
          term_hi_next[term_idx] = hi_merged[TERM_HI_W-1:0];
        end else begin
          term_lo_next[term_idx] = lo_merged;
        end
      end
    end
  end

  // configuration registers; erased array means every term is unused
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      small_reg <= CTRL_SMALL_RST;
      gsel_reg  <= CTRL_GSEL_RST;
      for (int c = 0; c < CELLS; c++) begin
        cell_cfg_reg[c] <= CELL_CFG_RST;
      end
      for (int s = 0; s < SLOTS; s++) begin
        term_lo_reg[s] <= TERM_LO_RST;
        term_hi_reg[s] <= TERM_HI_RST;
      end
    end else begin
      small_reg <= small_next;
      gsel_reg  <= gsel_next;
      for (int c = 0; c < CELLS; c++) begin
        cell_cfg_reg[c] <= cell_cfg_next[c];
      end
      for (int s = 0; s < SLOTS; s++) begin
        term_lo_reg[s] <= term_lo_next[s];
        term_hi_reg[s] <= term_hi_next[s];
      end
    end
  end

  // read mux over the current register contents; reserved bits read zero
  always_comb begin
    rd_word = 32'h00000000;
    if (hit_ctrl) begin
      rd_word[CTRL_SMALL_BIT]          = small_reg;
      rd_word[CTRL_GSEL_LSB +: GSEL_W] = gsel_reg;
    end else if (hit_status) begin
      rd_word[7:0]   = cell_q;
      rd_word[15:8]  = feedback;
      rd_word[23:16] = pin_oe;
      rd_word[31:24] = pin_in;
    end else if (hit_inputs) begin
      rd_word[DED_LARGE-1:0] = ded_in;
    end else if (hit_cell) begin
      rd_word[CELL_CFG_W-1:0] = cell_cfg_reg[cell_idx];
    end else if (hit_term) begin
      if (term_hi_sel) begin
        rd_word[TERM_HI_W-1:0] = term_hi_reg[term_idx];
      end else begin
        rd_word = term_lo_reg[term_idx];
      end
    end
  end

  // bus answer: one wait cycle per access, then a single acknowledge cycle;
  // a write answer leaves readdata alone so it holds until the next read
  always_comb begin
    wait_next  = 1'b1;
    rdata_next = rdata_reg;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      if (avs_read) begin
        rdata_next = rd_word;
      end
    end
  end

  // bus registers; readdata holds its last value between accesses
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata    = rdata_reg;

  // array signals: dedicated inputs first, then one feedback per cell
  assign sigs = {feedback, ded_in};
  assign keep = small_reg ? LIT_KEEP_SMALL : LIT_KEEP_LARGE;

  // true literal at even index, complement at odd index
  genvar g;
  generate
    for (g = 0; g < SIGS; g++) begin : g_lit
      assign lits[2*g]   = sigs[g];
      assign lits[2*g+1] = ~sigs[g];
    end
  endgenerate

  // shared enable pin; an index past the variant's inputs reads as disabled
  always_comb begin
    if (small_reg && (gsel_reg >= 4'(DED_SMALL))) begin
      global_oe = 1'b0;
    end else if (gsel_reg >= 4'(DED_LARGE)) begin
      global_oe = 1'b0;
    end else begin
      global_oe = ded_in[gsel_reg];
    end
  end

  // per-cell configuration fields, unpacked for the cell instances
  always_comb begin
    for (int k = 0; k < CELLS; k++) begin
      cell_registered[k] = cell_cfg_reg[k][CELL_REG_BIT];
      cell_invert[k]     = cell_cfg_reg[k][CELL_INV_BIT];
      cell_oe_mode[k]    = sopma_oe_e'(cell_cfg_reg[k][CELL_OE_LSB +: 2]);
      cell_dir[k]        = sopma_dir_e'(cell_cfg_reg[k][CELL_DIR_LSB +: 2]);
    end
  end

  // pin outputs are combinatorial on purpose: a registered cell already
  // drives from its flip-flop, and a combinatorial one must not gain a cycle
  genvar c;
  generate
    for (c = 0; c < CELLS; c++) begin : g_cell
      for (g = 0; g < TERMS; g++) begin : g_slot
        assign cell_masks[c][g*LITS +: LITS] = {term_hi_reg[c*TERMS+g],
                                                term_lo_reg[c*TERMS+g]};
      end
      sopma_cell u_cell (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .lits       (lits),
        .masks      (cell_masks[c]),
        .keep       (keep),
        .registered (cell_registered[c]),
        .invert     (cell_invert[c]),
        .oe_mode    (cell_oe_mode[c]),
        .dir        (cell_dir[c]),
        .global_oe  (global_oe),
        .pin_in     (pin_in[c]),
        .pin_out    (pin_out[c]),
        .pin_oe     (pin_oe[c]),
        .feedback   (feedback[c]),
        .q          (cell_q[c])
      );
    end
  endgenerate

endmodule : sopma_top
`default_nettype wire

// file: testbench/sopma_board.sv
// board logic around the macrocell pins: external drivers and wire resolution
`timescale 1ns/100ps
`default_nettype none

module sopma_board (
  // clock
  input  wire logic                        clk_sys,
  // device side
  input  wire logic [sopma_pkg::CELLS-1:0] pin_out,
  input  wire logic [sopma_pkg::CELLS-1:0] pin_oe,
  // board drivers
  input  wire logic [sopma_pkg::CELLS-1:0] ext_val,
  input  wire logic [sopma_pkg::CELLS-1:0] ext_en,
  // resolved wire
  output var  logic [sopma_pkg::CELLS-1:0] pin_in
);
  import sopma_pkg::*;

  logic [CELLS-1:0] float_reg = 8'h55;

  // no pull resistor, so an undriven wire wanders instead of holding
  always_ff @(posedge clk_sys) begin
    float_reg <= ~float_reg;
  end

  // device driver first, then the board driver, else the wandering level
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
           | (~pin_oe & ~ext_en & float_reg);
  end
endmodule : sopma_board

`default_nettype wire

// file: testbench/sopma_top_checker.sv
// concurrent checks on the ports of the macrocell array top
`timescale 1ns/100ps
`default_nettype none

module sopma_top_checker (
  // clock and reset
  input wire logic                         clk_sys,
  input wire logic                         rst,
  // register slave
  input wire logic [sopma_pkg::ADDR_W-1:0] avs_address,
  input wire logic                         avs_read,
  input wire logic                         avs_write,
  input wire logic [sopma_pkg::DATA_W-1:0] avs_readdata,
  input wire logic                         avs_waitrequest,
  // array inputs and pins
  input wire logic [sopma_pkg::DED_LARGE-1:0] ded_in,
  input wire logic [sopma_pkg::CELLS-1:0]  pin_in,
  input wire logic [sopma_pkg::CELLS-1:0]  pin_out,
  input wire logic [sopma_pkg::CELLS-1:0]  pin_oe
);
  import sopma_pkg::*;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // a request seen while waiting, then a single low cycle of waitrequest
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  chk_bus_answer: assert property (s_taken |=> s_answer)
    else $error("access not answered in one cycle");
  chk_bus_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped without a request");
  chk_rdata_hold: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data moved outside a read answer");
  chk_write_nodata: assert property (!avs_waitrequest && avs_write |-> $stable(avs_readdata))
    else $error("read data moved on a write answer");
  chk_ded_read: assert property (
    avs_read && !avs_waitrequest && avs_address == REG_INPUTS
    |-> avs_readdata == {18'h00000, $past(ded_in)})
    else $error("input word differs from dedicated inputs");
  chk_status_pins: assert property (
    avs_read && !avs_waitrequest && avs_address == REG_STATUS
    |-> avs_readdata[31:16] == {$past(pin_in), $past(pin_oe)})
    else $error("status pin fields differ from pins");
  chk_unmapped_zero: assert property (
    avs_read && !avs_waitrequest && avs_address == 9'h003 |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_reset_pins: assert property ($fell(rst) |-> pin_oe == 8'h00 && pin_out == 8'h00)
    else $error("pins not quiet after reset");
endmodule : sopma_top_checker

bind sopma_top sopma_top_checker chk_u (
  .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .ded_in(ded_in), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
);

`default_nettype wire

// file: testbench/tb.sv
// self-checking bench: register slave tasks and pin scenarios
`timescale 1ns/100ps
`default_nettype none

module tb;
  import sopma_pkg::*;

  logic                 clk_sys;
  logic                 rst;
  logic [ADDR_W-1:0]    avs_address;
  logic                 avs_read;
  logic                 avs_write;
  logic [DATA_W-1:0]    avs_writedata;
  logic [DATA_W-1:0]    avs_readdata;
  logic                 avs_waitrequest;
  logic [DED_LARGE-1:0] ded_in;
  logic [CELLS-1:0]     pin_in;
  logic [CELLS-1:0]     pin_out;
  logic [CELLS-1:0]     pin_oe;
  logic [CELLS-1:0]     ext_val;
  logic [DATA_W-1:0]    rdat;
  logic                 q_prev;
  int                   errors;
  int                   n_tests;
  // enable modes: cell setting, dedicated inputs, expected enable
  logic [5:0]           oe_cfg [8] = '{6'h00, 6'h00, 6'h04, 6'h08, 6'h08, 6'h0C, 6'h2C, 6'h14};
  logic [13:0]          oe_ded [8] = '{14'h4, 14'h0, 14'h0, 14'h20, 14'h0, 14'h4, 14'h0, 14'h24};
  logic [7:0]           oe_exp     = 8'b0100_1101;

  sopma_top dut_u (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ded_in(ded_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe)
  );

  // cells 1 and 2 are driven from the board side
  sopma_board board_u (
    .clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
    .ext_en(8'h06), .pin_in(pin_in)
  );

  task automatic stop_test;
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp32

  task automatic cmp1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp1

  // one access; held until waitrequest is sampled low
  task automatic bus_acc(input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus_acc

  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] unused;
    bus_acc(1'b1, a, d, unused);
  endtask : bus_wr

  // a 44-bit term mask spans an even and an odd word
  task automatic set_term(input int c, input int t, input logic [43:0] m);
    logic [ADDR_W-1:0] a;
    a = REG_TERM_BASE + ADDR_W'(2 * (c * TERMS + t));
    bus_wr(a, m[31:0]);
    bus_wr(a + 9'h001, {20'h00000, m[43:32]});
  endtask : set_term

  // new pin-side stimulus, checked once the combinational array settles
  task automatic pins_at(input logic [13:0] d, input logic [7:0] ev);
    @(posedge clk_sys);
    ded_in  <= d;
    ext_val <= ev;
    @(negedge clk_sys);
  endtask : pins_at

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // hang guard, well past the hundred or so cycles the tests need
  initial begin
    #100000;
    errors++;
    stop_test();
  end

  initial begin
    rst = 1'b1; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = '0; ded_in = '0; ext_val = '0; errors = 0; n_tests = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    // quiet pins and cleared settings after reset, unmapped word ignored
    @(negedge clk_sys);
    cmp32({16'h0000, pin_oe, pin_out}, 32'h00000000);
    bus_acc(1'b0, REG_GLOBAL_CTRL, '0, rdat);
    cmp32(rdat, 32'h00000000);
    bus_acc(1'b0, REG_CELL_BASE, '0, rdat);
    cmp32(rdat, {26'h0000000, CELL_CFG_RST});
    bus_wr(9'h003, 32'hFFFFFFFF);
    bus_acc(1'b0, 9'h003, '0, rdat);
    cmp32(rdat, 32'h00000000);
    // cell 0: ded0 & ~ded1 or ded13, output only
    bus_wr(REG_CELL_BASE, 32'h00000020);
    set_term(0, 0, 44'h00000000009);
    set_term(0, 7, 44'h00004000000);
    for (int i = 0; i < 4; i++) begin
      pins_at(i[1] ? 14'h2000 : {12'h000, i[0], 1'b1}, 8'h00);
      cmp1(pin_out[0], ~i[0] | i[1]);
    end
    cmp1(pin_oe[0], 1'b1);
    bus_wr(REG_GLOBAL_CTRL, 32'h00000001);
    pins_at(14'h2000, 8'h00);
    cmp1(pin_out[0], 1'b0);
    bus_wr(REG_GLOBAL_CTRL, 32'h00000500);
    bus_wr(REG_CELL_BASE, 32'h00000022);
    pins_at(14'h0001, 8'h00);
    cmp1(pin_out[0], 1'b0);
    // cell 1 registered, never enabled, toggles from its own flop
    bus_wr(REG_CELL_BASE + 9'h001, 32'h0000000D);
    set_term(1, 0, 44'h00080000000);
    @(negedge clk_sys);
    q_prev = pin_out[1];
    repeat (3) begin
      @(negedge clk_sys);
      cmp1(pin_out[1], ~q_prev);
      q_prev = pin_out[1];
    end
    cmp1(pin_oe[1], 1'b0);
    // the board holds pin 1 low, so a pin-fed loop would miss a high flop phase
    repeat (2) begin
      bus_acc(1'b0, REG_STATUS, '0, rdat);
      cmp1(rdat[9], rdat[1]);
    end
    // cell 2 input only feeds cell 3 through its pin
    bus_wr(REG_CELL_BASE + 9'h002, 32'h00000010);
    bus_wr(REG_CELL_BASE + 9'h003, 32'h00000020);
    set_term(3, 0, 44'h00100000000);
    for (int v = 0; v < 2; v++) begin
      pins_at(14'h0000, {5'h00, v[0], 2'b00});
      cmp1(pin_out[3], v[0]);
      cmp1(pin_oe[2], 1'b0);
    end
    // cell 4 through every enable source and the bidir, input-only and output pin uses
    set_term(4, OE_TERM, 44'h00000000010);
    for (int k = 0; k < 8; k++) begin
      bus_wr(REG_CELL_BASE + 9'h004, {26'h0000000, oe_cfg[k]});
      pins_at(oe_ded[k], 8'h00);
      cmp1(pin_oe[4], oe_exp[k]);
    end
    bus_acc(1'b0, REG_INPUTS, '0, rdat);
    cmp32(rdat, {18'h00000, oe_ded[7]});
    stop_test();
  end
endmodule : tb

`default_nettype wire
